// File: logic/adcrc_top.sv
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "adcrc_map.svh"

module adcrc_top (
    input wire logic CLK, // system clock, 20 MHz
    input wire logic RST, // async reset, high
    input wire logic HSEL, // slave select
    input wire logic [7:0] HADDR, // byte address
    input wire logic [1:0] HTRANS, // transfer type
    input wire logic HWRITE, // write strobe
    input wire logic [2:0] HSIZE, // transfer size
    input wire logic HREADY, // bus ready in
    input wire logic [31:0] HWDATA, // write data
    output logic [31:0] HRDATA, // read data
    output logic HREADYOUT, // slave ready
    output logic HRESP, // always okay
    output logic REF_FROM_EXT_PIN, // reference source select
    output logic REF_PIN_OTHER_FUNC_EN, // shared pin other functions
    output logic CONV_CLK, // converter clock
    output logic CONV_CLK_TICK, // converter clock period pulse, high every cycle at code 0
    output logic [3:0] ANALOG_CHANNEL_EN // port A pin 3..0 analog
);

    logic reference_source_select;
    logic [2:0] conv_clock_div;
    logic [3:0] analog_channel_enable;
    logic wr_pending;
    logic [7:0] wr_addr;
    logic addr_valid;
    adcrc_pkg::adcrc_phase_t phase;
    logic [31:0] next_rdata;
    logic div_clk;
    logic div_tick;
    logic cfg_wr;
    logic chan_wr;

    // --------------------------------------------------------
    // register map
    // --------------------------------------------------------
    // word 0x00, converter config:
    //   bit 4 reference source, 0 supply pin, 1 external pin
    //   bits 2..0 converter clock divide code, 1 to 64
    //   bits 5 and 3 have no flop and always read zero
    // word 0x04, channel enable:
    //   bits 3..0 turn port A pins 3..0 into analog inputs
    //   bits 7..4 have no flop and always read zero
    // any other word reads zero and swallows writes, OKAY
    // upper bits of every word read zero; no field sits there

    // --------------------------------------------------------
    // bus address phase
    // --------------------------------------------------------
    // timing, all with zero wait states:
    //   edge 1 takes the address phase
    //   read data is captured at edge 1 and stands in data phase
    //   write data is taken from HWDATA at edge 2
    //   the port copies of a written field move at edge 3
    // a read issued right after a write to the same word sees
    // the old value; software needs one idle cycle in between
    // HSIZE is not decoded: narrow writes land as whole words,
    // so software must only use word accesses

    // only NONSEQ/SEQ with select and ready start a transfer
    assign addr_valid = HSEL && HREADY && HTRANS[1];

    // write address captured for the data phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            phase <= adcrc_pkg::ADCRC_IDLE;
        end else begin
            wr_pending <= addr_valid && HWRITE;
            wr_addr <= HADDR;
            phase <= addr_valid ? adcrc_pkg::ADCRC_DATA
                                : adcrc_pkg::ADCRC_IDLE;
        end
    end

    // zero wait states; errors never raised
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // --------------------------------------------------------
    // write strobes
    // --------------------------------------------------------
    // decoded in the data phase, when HWDATA is valid
    assign cfg_wr = (phase == adcrc_pkg::ADCRC_DATA) && wr_pending &&
                    (wr_addr == `ADCRC_OFS_CONV_CONFIG);
    assign chan_wr = (phase == adcrc_pkg::ADCRC_DATA) && wr_pending &&
                     (wr_addr == `ADCRC_OFS_CHAN_ENABLE);

    // --------------------------------------------------------
    // register storage
    // --------------------------------------------------------
    // config word: only bits 4 and 2..0 have storage
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            reference_source_select <= `ADCRC_RST_REF_SEL;
            conv_clock_div <= `ADCRC_RST_DIV;
        end else if (cfg_wr) begin
            reference_source_select <= HWDATA[`ADCRC_REF_SEL_BIT];
            // code 111 is stored as written; software must avoid it
            conv_clock_div <= HWDATA[`ADCRC_DIV_MSB:`ADCRC_DIV_LSB];
        end
    end

    // channel enables, one flop per pin, set at reset so the
    // pins start as analog inputs until software frees them
    localparam logic [3:0] chan_rst_val = `ADCRC_RST_CHAN;
    genvar gi;
    generate
        for (gi = 0; gi <= `ADCRC_CHAN_MSB; gi++) begin : g_chan
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    analog_channel_enable[gi] <= chan_rst_val[gi];
                end else if (chan_wr) begin
                    analog_channel_enable[gi] <= HWDATA[gi];
                end
            end
        end
    endgenerate

    // --------------------------------------------------------
    // read data
    // --------------------------------------------------------
    // unimplemented bits are constant zero, no storage behind them
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_valid && !HWRITE) begin
            case (HADDR)
                `ADCRC_OFS_CONV_CONFIG: begin
                    next_rdata[`ADCRC_REF_SEL_BIT] = reference_source_select;
                    next_rdata[`ADCRC_DIV_MSB:`ADCRC_DIV_LSB] =
                        conv_clock_div;
                end
                `ADCRC_OFS_CHAN_ENABLE: begin
                    next_rdata[`ADCRC_CHAN_MSB:0] =
                        analog_channel_enable;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // read data registered at the address phase edge
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_valid) begin
            HRDATA <= next_rdata;
        end
    end

    // --------------------------------------------------------
    // converter clock
    // --------------------------------------------------------
    // the divider reads the stored code directly, so a new code
    // takes effect from the edge after the write; the first
    // period after a change may be short
    // code 111 has no defined rate; it runs as divide by 64 here
    // only so the level never stalls, and must not be relied on
    adcrc_clkdiv u_div (
        .clk(CLK),
        .rst(RST),
        .div_code(conv_clock_div),
        .conv_clk(div_clk),
        .conv_tick(div_tick)
    );

    // --------------------------------------------------------
    // outputs to converter core and pin mux
    // --------------------------------------------------------
    // one extra flop keeps every output registered in this module;
    // the price is one cycle of lag behind the stored fields

    // reference routing; the shared pin loses its other uses
    // whenever the external reference is chosen
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REF_FROM_EXT_PIN <= 1'b0;
            REF_PIN_OTHER_FUNC_EN <= 1'b1;
        end else begin
            REF_FROM_EXT_PIN <= reference_source_select;
            REF_PIN_OTHER_FUNC_EN <= ~reference_source_select;
        end
    end

    // converter clock level and period pulse
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CONV_CLK <= 1'b0;
            CONV_CLK_TICK <= 1'b0;
        end else begin
            CONV_CLK <= div_clk;
            CONV_CLK_TICK <= div_tick;
        end
    end

    // pin mux: port A pins 3..0 as analog inputs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ANALOG_CHANNEL_EN <= `ADCRC_RST_CHAN;
        end else begin
            ANALOG_CHANNEL_EN <= analog_channel_enable;
        end
    end

endmodule

// File: logic/adcrc_map.svh
`ifndef ADCRC_MAP_SVH
`define ADCRC_MAP_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define ADCRC_OFS_CONV_CONFIG 8'h00
`define ADCRC_OFS_CHAN_ENABLE 8'h04

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ADCRC_REF_SEL_BIT 4
`define ADCRC_DIV_MSB 2
`define ADCRC_DIV_LSB 0
`define ADCRC_CHAN_MSB 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ADCRC_RST_REF_SEL 1'h0
`define ADCRC_RST_DIV 3'h0
`define ADCRC_RST_CHAN 4'hf

// ------------------------------------------------------------
// timing counts
// ------------------------------------------------------------
`define ADCRC_DIV_CNT_W 6
`define ADCRC_DIV_UNDEF 3'h7

`endif

// File: logic/adcrc_pkg.sv
package adcrc_pkg;

    // converter clock divide codes
    typedef enum logic [2:0] {
        ADCRC_DIV1 = 3'b000,
        ADCRC_DIV2 = 3'b001,
        ADCRC_DIV4 = 3'b010,
        ADCRC_DIV8 = 3'b011,
        ADCRC_DIV16 = 3'b100,
        ADCRC_DIV32 = 3'b101,
        ADCRC_DIV64 = 3'b110,
        ADCRC_DIVX = 3'b111
    } adcrc_div_t;

    // bus slave phase
    typedef enum logic [0:0] {
        ADCRC_IDLE = 1'b0,
        ADCRC_DATA = 1'b1
    } adcrc_phase_t;

endpackage

// File: logic/adcrc_clkdiv.sv
`timescale 1ns/1ns
`include "adcrc_map.svh"

module adcrc_clkdiv (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [2:0] div_code, // divide code
    output logic conv_clk, // divided clock level
    output logic conv_tick // one-cycle pulse per period; high every cycle for code 0
);

    logic [`ADCRC_DIV_CNT_W-1:0] count;
    logic [`ADCRC_DIV_CNT_W-1:0] next_count;
    logic [`ADCRC_DIV_CNT_W-1:0] half_mask;
    logic wrap;

    // --------------------------------------------------------
    // divider
    // --------------------------------------------------------
    // counter wraps at 2^code-1; bit code-1 gives 50% duty
    always_comb begin
        half_mask = '0;
        case (adcrc_pkg::adcrc_div_t'(div_code))
            adcrc_pkg::ADCRC_DIV1: half_mask = 6'h00;
            adcrc_pkg::ADCRC_DIV2: half_mask = 6'h01;
            adcrc_pkg::ADCRC_DIV4: half_mask = 6'h03;
            adcrc_pkg::ADCRC_DIV8: half_mask = 6'h07;
            adcrc_pkg::ADCRC_DIV16: half_mask = 6'h0f;
            adcrc_pkg::ADCRC_DIV32: half_mask = 6'h1f;
            adcrc_pkg::ADCRC_DIV64: half_mask = 6'h3f;
            // undefined code: held at divide by 64, not relied upon
            default: half_mask = 6'h3f;
        endcase
        wrap = ((count & half_mask) == half_mask);
        next_count = wrap ? 6'h00 : 6'(count + 6'h01);
    end

    // counter; a code change restarts cleanly within one period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count & half_mask;
        end
    end

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_clk <= 1'b0;
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= wrap;
            if (half_mask == 6'h00) begin
                conv_clk <= ~conv_clk;
            end else begin
                conv_clk <= |(next_count & ~(half_mask >> 1) & half_mask);
            end
        end
    end

endmodule

// File: test/adcrc_monitor.sv
`timescale 1ns/1ns
// --------------------
// port-level checker
// --------------------
module adcrc_monitor (
    input wire logic CLK, // clock
    input wire logic RST, // reset
    input wire logic HSEL, // select
    input wire logic [7:0] HADDR, // address
    input wire logic [1:0] HTRANS, // type
    input wire logic HWRITE, // write
    input wire logic HREADY, // ready in
    input wire logic [31:0] HWDATA, // wdata
    input wire logic [31:0] HRDATA, // rdata
    input wire logic HREADYOUT, // ready out
    input wire logic HRESP, // response
    input wire logic REF_FROM_EXT_PIN, // ref select
    input wire logic REF_PIN_OTHER_FUNC_EN, // pin share
    input wire logic [3:0] ANALOG_CHANNEL_EN // channels
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // accepted address phase
    wire take = HSEL && HREADY && HTRANS[1];
    AST_REF_MUX: assert property (
        REF_PIN_OTHER_FUNC_EN != REF_FROM_EXT_PIN) else $error("pin share");
    AST_CHAN_RST: assert property (
        $past(RST) |-> ANALOG_CHANNEL_EN == 4'hf) else $error("chan reset");
    AST_REF_RST: assert property (
        $past(RST) |-> !REF_FROM_EXT_PIN) else $error("ref reset");
    // ports follow one cycle after the register
    AST_CHAN_WR: assert property (
        take && HWRITE && HADDR == 8'h04 |=> ##2
        ANALOG_CHANNEL_EN == $past(HWDATA[3:0], 2)) else $error("chan wr");
    AST_REF_WR: assert property (
        take && HWRITE && HADDR == 8'h00 |=> ##2
        REF_FROM_EXT_PIN == $past(HWDATA[4], 2)) else $error("ref wr");
    AST_CFG_RD: assert property (
        take && !HWRITE && HADDR == 8'h00 |=>
        HRDATA[5] == 1'b0 && HRDATA[3] == 1'b0) else $error("cfg hole");
    AST_CHAN_RD: assert property (
        take && !HWRITE && HADDR == 8'h04 |=>
        HRDATA[31:4] == 28'h0) else $error("chan upper");
    AST_ZERO_WAIT: assert property (
        HREADYOUT && !HRESP) else $error("bus wait or error");
endmodule

bind adcrc_top adcrc_monitor mon (.CLK, .RST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HREADY, .HWDATA, .HRDATA, .HREADYOUT, .HRESP,
    .REF_FROM_EXT_PIN, .REF_PIN_OTHER_FUNC_EN, .ANALOG_CHANNEL_EN);

// File: test/adcrc_top_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module adcrc_top_tb;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [7:0] HADDR = 8'h00;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HWDATA = 32'h0;
    wire logic [31:0] HRDATA;
    wire logic HREADYOUT, HRESP, REF_FROM_EXT_PIN, REF_PIN_OTHER_FUNC_EN;
    wire logic CONV_CLK, CONV_CLK_TICK;
    wire logic [3:0] ANALOG_CHANNEL_EN;
    int fails = 0;
    int check_count = 0;

    adcrc_top uut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
        .HREADY(HREADYOUT), .HWDATA, .HRDATA, .HREADYOUT, .HRESP,
        .REF_FROM_EXT_PIN, .REF_PIN_OTHER_FUNC_EN, .CONV_CLK,
        .CONV_CLK_TICK, .ANALOG_CHANNEL_EN);

    // --------------------
    // clock, bus master
    // --------------------
    initial forever #25 CLK = ~CLK;

    // single transfer plus one idle cycle, so reads see prior writes
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q);
        HSEL <= 1'b1;
        HADDR <= a;
        HWRITE <= w;
        HTRANS <= 2'h2;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
        @(posedge CLK);
    endtask

    // --------------------
    // scenarios
    // --------------------
    task automatic t_reset();
        logic [31:0] q;
        bus(8'h00, 1'b0, 32'h0, q);
        `CHK(q, 32'h0)
        bus(8'h04, 1'b0, 32'h0, q);
        `CHK(q, 32'hf)
        `CHK(ANALOG_CHANNEL_EN, 4'hf)
        `CHK(REF_FROM_EXT_PIN, 1'b0)
        `CHK(REF_PIN_OTHER_FUNC_EN, 1'b1)
    endtask

    // near all-ones write with bits 3 and 0 clear, code 111 avoided
    task automatic t_cfg();
        logic [31:0] q;
        bus(8'h00, 1'b1, 32'hfffffff6, q);
        bus(8'h00, 1'b0, 32'h0, q);
        `CHK(q, 32'h16)
        `CHK(REF_FROM_EXT_PIN, 1'b1)
        `CHK(REF_PIN_OTHER_FUNC_EN, 1'b0)
        bus(8'h00, 1'b1, 32'h28, q);
        bus(8'h00, 1'b0, 32'h0, q);
        `CHK(q, 32'h0)
        `CHK(REF_FROM_EXT_PIN, 1'b0)
        `CHK(REF_PIN_OTHER_FUNC_EN, 1'b1)
    endtask

    task automatic t_chan();
        logic [31:0] q;
        for (int i = 0; i < 16; i++) begin
            bus(8'h04, 1'b1, 32'hfffffff0 | i, q);
            bus(8'h04, 1'b0, 32'h0, q);
            `CHK(q, 32'(i))
            `CHK(ANALOG_CHANNEL_EN, 4'(i))
        end
        // unmapped word: ignored, reads zero
        bus(8'h08, 1'b1, 32'h0, q);
        bus(8'h08, 1'b0, 32'h0, q);
        `CHK(q, 32'h0)
        `CHK(ANALOG_CHANNEL_EN, 4'hf)
    endtask

    // count ticks and clock rises over 128 cycles, a multiple of
    // every period; code 0 toggles the level, so its period is 2
    task automatic t_div();
        logic [31:0] q;
        int n;
        int r;
        logic prev;
        for (int c = 0; c < 7; c++) begin
            bus(8'h00, 1'b1, 32'(c), q);
            repeat (140) @(posedge CLK);
            n = 0;
            r = 0;
            prev = CONV_CLK;
            repeat (128) begin
                @(posedge CLK);
                n += (CONV_CLK_TICK === 1'b1);
                r += (CONV_CLK === 1'b1 && prev === 1'b0);
                prev = CONV_CLK;
            end
            `CHK(n, 128 >> c)
            `CHK(r, (c == 0) ? 64 : (128 >> c))
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        t_reset();
        t_cfg();
        t_chan();
        t_div();
        summarize();
    end

    // watchdog, about three times the expected run
    initial begin
        repeat (6000) @(posedge CLK);
        fails++;
        summarize();
    end
endmodule
